// ---- hw/ioport_pkg.sv ----
// Package: constants, types and helpers for the port configuration block.
package ioport_pkg;

    // Port count and width; ports A..G are indices 0..6.
    localparam int NPORT = 7;
    localparam int PW = 8;
    localparam int PORT_E = 4;
    localparam int PORT_F = 5;
    localparam int PORT_G = 6;

    // Register groups, each holding one byte per port at index offset except the single map byte, then the group and index masks.
    localparam logic [7:0] OFS_DIN = 8'h00;
    localparam logic [7:0] OFS_DOUT = 8'h08;
    localparam logic [7:0] OFS_DIR = 8'h10;
    localparam logic [7:0] OFS_DRV = 8'h18;
    localparam logic [7:0] OFS_MODE = 8'h20;
    localparam logic [7:0] OFS_MAP = 8'h28;
    localparam logic [7:0] OFS_GRP = 8'hF8;
    localparam logic [7:0] OFS_IDX = 8'h07;

    // Reset value of every setup register and the buffer mode bit.
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam int MAP_PERIPH_BIT = 7;

    // Test access pins on port E: select, clock, data in, data out.
    localparam int JT_TMS = 0;
    localparam int JT_TCK = 1;
    localparam int JT_TDI = 2;
    localparam int JT_TDO = 3;

    // Implemented bits per port, port G in the leftmost byte.
    localparam logic [NPORT-1:0][7:0] DIR_MASK =
        {8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'hFF, 8'hFF, 8'hFF};
    localparam logic [NPORT-1:0][7:0] DRV_MASK =
        {8'hFF, 8'h00, 8'hFF, 8'h0F, 8'h00, 8'hFF, 8'hFF};
    localparam logic [NPORT-1:0][7:0] MODE_MASK =
        {8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam logic [NPORT-1:0][7:0] OE_TERM_MASK =
        {8'h00, 8'hFF, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF};
    localparam logic [NPORT-1:0][7:0] ADDR_IN_MASK =
        {8'h00, 8'hFF, 8'h00, 8'h0F, 8'hFF, 8'hFF, 8'hFF};

    // One byte per port for all pin-wide quantities.
    typedef logic [NPORT-1:0][PW-1:0] port_vec_t;

    // Host register cycle, one-cycle strobes.
    typedef struct packed {
        logic sel;
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } host_req_t;

    // Host read answer.
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } host_rsp_t;

    // Per-port driver request: value, enable, open-drain select.
    typedef struct packed {
        logic [PW-1:0] val;
        logic [PW-1:0] en;
        logic [PW-1:0] od;
    } drv_req_t;

    // Per-port pin drive: level and output enable.
    typedef struct packed {
        logic [PW-1:0] o;
        logic [PW-1:0] oe;
    } pin_drv_t;

    // Keeps only the implemented bits of a register byte.
    function automatic logic [7:0] keep_bits(input logic [7:0] d,
                                             input logic [7:0] m);
        keep_bits = d & m;
    endfunction : keep_bits

endpackage : ioport_pkg

// ---- hw/level_sync.sv ----
// Two-stage synchroniser for a bundle of asynchronous levels.
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
    parameter int W = 8
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst,
    // Asynchronous levels in, synchronised levels out.
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    // First stage, read only by the second stage.
    logic [W-1:0] meta_reg;

    // Both stages clear to zero under reset.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            meta_reg <= '0;
            q <= '0;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end

endmodule : level_sync
`default_nettype wire

// ---- hw/pin_driver.sv ----
// Pin driver for one port: push-pull or open-drain per pin.
`timescale 1ns/1ps
`default_nettype none
module pin_driver (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst,
    // Requested drive.
    input wire ioport_pkg::drv_req_t req,
    // Pin level and enable.
    output ioport_pkg::pin_drv_t drv
);
    import ioport_pkg::*;

    // Registered drive and its next value.
    pin_drv_t drv_reg;
    pin_drv_t drv_next;

    // Open drain pins only sink a low; a one releases the pin.
    always_comb begin
        drv_next.o = req.val & ~req.od;
        drv_next.oe = req.en & (~req.od | ~req.val);
    end

    // Pins float after reset.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            drv_reg <= '0;
        end else begin
            drv_reg <= drv_next;
        end
    end

    assign drv = drv_reg;

endmodule : pin_driver
`default_nettype wire

// ---- hw/port_config_top.sv ----
// Port configuration, mode selection and pin drive for ports A to G.
`timescale 1ns/1ps
`default_nettype none
module port_config_top (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst,
    // Host register cycles on the I/O register block.
    input wire ioport_pkg::host_req_t host_req,
    output ioport_pkg::host_rsp_t host_rsp,
    // Port pins, split into level in, level out and enable.
    input wire ioport_pkg::port_vec_t pin_in,
    output ioport_pkg::port_vec_t pin_out,
    output ioport_pkg::port_vec_t pin_oe,
    // Programmable logic side of the ports.
    input wire ioport_pkg::port_vec_t logic_out_val,
    input wire ioport_pkg::port_vec_t logic_oe_term,
    input wire ioport_pkg::port_vec_t addr_out_val,
    input wire ioport_pkg::port_vec_t decode_use,
    input wire logic address_latch_strobe,
    output ioport_pkg::port_vec_t addr_in_live,
    output ioport_pkg::port_vec_t input_latch_cell,
    output ioport_pkg::port_vec_t decode_addr_in,
    // Data port for a host with separate address and data.
    input wire logic data_port_mode,
    input wire logic data_port_drive,
    input wire logic [15:0] data_port_rdata,
    output logic [15:0] data_port_wdata,
    // Peripheral buffer on port F.
    input wire logic peripheral_select_zero,
    input wire logic peripheral_select_one,
    input wire logic periph_host_write,
    input wire logic [7:0] periph_wdata,
    output logic [7:0] periph_rdata,
    output logic periph_mode,
    // Reset pattern onto the host data lines.
    input wire logic reset_pattern_mode,
    input wire logic [15:0] reset_pattern,
    input wire logic host_reset,
    input wire logic bus_cycle_active,
    // Test access sharing on port E.
    input wire logic jtag_enable,
    input wire logic jtag_tdo,
    output logic jtag_tms,
    output logic jtag_tck,
    output logic jtag_tdi
);
    import ioport_pkg::*;

    // Setup registers, one byte per port, and their next values.
    port_vec_t mode_reg;
    port_vec_t mode_next;
    port_vec_t dir_reg;
    port_vec_t dir_next;
    port_vec_t drv_reg;
    port_vec_t drv_next;
    port_vec_t dout_reg;
    port_vec_t dout_next;
    // Memory map mode register; bit 7 enables the peripheral buffer.
    logic [7:0] memory_map_mode_register_reg;
    logic [7:0] memory_map_mode_register_next;

    // Host read answer and its next value.
    host_rsp_t rsp_reg;
    host_rsp_t rsp_next;

    // Address latch cell contents and next value.
    port_vec_t latch_reg;
    port_vec_t latch_next;

    // Synchronised pins, strobe and host reset.
    port_vec_t pin_sync;
    logic strobe_sync;
    logic reset_sync;

    // Per-port drive requests and resulting pin drives.
    drv_req_t [NPORT-1:0] req;
    pin_drv_t [NPORT-1:0] drv;

    // Decoded register cycle fields.
    logic [7:0] grp;
    logic [2:0] idx;
    logic idx_ok;

    // Active mode flags for ports F and G.
    logic pattern_on;
    logic buffer_on;
    logic buffer_conduct;

    // All pins, the strobe and the host reset cross two flip-flops.
    level_sync #(
        .W(NPORT * PW + 2)
    ) u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .d({pin_in, address_latch_strobe, host_reset}),
        .q({pin_sync, strobe_sync, reset_sync})
    );

    // Cycle decode: group from upper offset bits, port from lower ones.
    always_comb begin
        grp = host_req.addr & OFS_GRP;
        idx = host_req.addr[2:0] & OFS_IDX[2:0];
        idx_ok = (idx < 3'(NPORT));
    end

    // Register writes; unimplemented bits are never stored.
    always_comb begin
        mode_next = mode_reg;
        dir_next = dir_reg;
        drv_next = drv_reg;
        dout_next = dout_reg;
        memory_map_mode_register_next = memory_map_mode_register_reg;
        if (host_req.sel && host_req.wr) begin
            if (grp == OFS_MAP && idx == 3'h0) begin
                memory_map_mode_register_next = host_req.wdata;
            end else if (idx_ok) begin
                unique case (grp)
                    // Output data holds all eight bits of each port.
                    OFS_DOUT: begin
                        dout_next[idx] = host_req.wdata;
                    end
                    // Direction: port D keeps only its low four bits.
                    OFS_DIR: begin
                        dir_next[idx] = keep_bits(host_req.wdata,
                                                  DIR_MASK[idx]);
                    end
                    // Drive type only where the port has the register.
                    OFS_DRV: begin
                        drv_next[idx] = keep_bits(host_req.wdata,
                                                  DRV_MASK[idx]);
                    end
                    // Pin mode only on ports E, F and G.
                    OFS_MODE: begin
                        mode_next[idx] = keep_bits(host_req.wdata,
                                                   MODE_MASK[idx]);
                    end
                    // Data-in and unused groups ignore writes.
                    default: begin
                        mode_next = mode_reg;
                    end
                endcase
            end
        end
    end

    // Setup registers clear to zero, so pins start as host inputs.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mode_reg <= {NPORT{CFG_RST}};
            dir_reg <= {NPORT{CFG_RST}};
            drv_reg <= {NPORT{CFG_RST}};
            dout_reg <= {NPORT{CFG_RST}};
            memory_map_mode_register_reg <= CFG_RST;
        end else begin
            mode_reg <= mode_next;
            dir_reg <= dir_next;
            drv_reg <= drv_next;
            dout_reg <= dout_next;
            memory_map_mode_register_reg <= memory_map_mode_register_next;
        end
    end

    // Read path; an unmapped offset answers zero.
    always_comb begin
        rsp_next.valid = host_req.sel && host_req.rd;
        rsp_next.data = 8'h00;
        if (host_req.sel && host_req.rd) begin
            if (grp == OFS_MAP && idx == 3'h0) begin
                rsp_next.data = memory_map_mode_register_reg;
            end else if (idx_ok) begin
                unique case (grp)
                    // Data-in returns the live synchronised pin levels.
                    OFS_DIN: begin
                        rsp_next.data = pin_sync[idx];
                    end
                    // Output data reads back as written.
                    OFS_DOUT: begin
                        rsp_next.data = dout_reg[idx];
                    end
                    // Setup registers read back their stored bits.
                    OFS_DIR: begin
                        rsp_next.data = dir_reg[idx];
                    end
                    OFS_DRV: begin
                        rsp_next.data = drv_reg[idx];
                    end
                    OFS_MODE: begin
                        rsp_next.data = mode_reg[idx];
                    end
                    // Anything else reads as zero.
                    default: begin
                        rsp_next.data = 8'h00;
                    end
                endcase
            end
        end
    end

    // Answer register; the answer stands for one cycle.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rsp_reg <= '0;
        end else begin
            rsp_reg <= rsp_next;
        end
    end

    assign host_rsp = rsp_reg;

    // Pattern only while the host is in reset and the bus is idle.
    always_comb begin
        pattern_on = reset_pattern_mode && reset_sync
                     && !bus_cycle_active;
        buffer_on = memory_map_mode_register_reg[MAP_PERIPH_BIT];
        buffer_conduct = buffer_on && (peripheral_select_zero
                                       || peripheral_select_one);
    end

    // Address latch cell: follows pins while the strobe is high.
    always_comb begin
        latch_next = latch_reg;
        if (strobe_sync) begin
            latch_next = pin_sync & ADDR_IN_MASK;
        end
    end

    // Latch cell clears to zero.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            latch_reg <= '0;
        end else begin
            latch_reg <= latch_next;
        end
    end

    // Per-port drive selection, bit n of each register on pin n.
    always_comb begin
        for (int p = 0; p < NPORT; p++) begin
            // Host I/O: direction OR logic enable on ports A,B,C,F.
            req[p].en = dir_reg[p]
                        | (logic_oe_term[p] & OE_TERM_MASK[p]);
            req[p].val = (logic_out_val[p] & logic_oe_term[p]
                          & OE_TERM_MASK[p]) | (dout_reg[p]
                          & ~(logic_oe_term[p] & OE_TERM_MASK[p]));
            // Address out replaces data where the mode bit is set.
            for (int b = 0; b < PW; b++) begin
                if (mode_reg[p][b]) begin
                    req[p].val[b] = addr_out_val[p][b];
                end
            end
            req[p].od = drv_reg[p];
        end
        // Port E pins 0 to 3 give way to the test port while it is enabled.
        if (jtag_enable) begin
            req[PORT_E].en[JT_TMS] = 1'b0;
            req[PORT_E].en[JT_TCK] = 1'b0;
            req[PORT_E].en[JT_TDI] = 1'b0;
            req[PORT_E].en[JT_TDO] = 1'b1;
            req[PORT_E].val[JT_TDO] = jtag_tdo;
            req[PORT_E].od[JT_TDO] = 1'b0;
        end
        // Port F as peripheral buffer, enabled only by a select with a host write.
        if (buffer_on) begin
            req[PORT_F].en = {PW{buffer_conduct && periph_host_write}};
            req[PORT_F].val = periph_wdata;
            req[PORT_F].od = '0;
        end
        // Data port replaces general I/O on F and G.
        if (data_port_mode) begin
            req[PORT_F].en = {PW{data_port_drive}};
            req[PORT_G].en = {PW{data_port_drive}};
            req[PORT_F].val = data_port_rdata[7:0];
            req[PORT_G].val = data_port_rdata[15:8];
            req[PORT_F].od = '0;
            req[PORT_G].od = '0;
        end
        // Reset pattern wins over every other use of F and G.
        if (pattern_on) begin
            req[PORT_F].en = '1;
            req[PORT_G].en = '1;
            req[PORT_F].val = reset_pattern[7:0];
            req[PORT_G].val = reset_pattern[15:8];
            req[PORT_F].od = '0;
            req[PORT_G].od = '0;
        end
    end

    // One driver per port; pins settle one cycle after a change.
    for (genvar g = 0; g < NPORT; g++) begin : g_drv
        pin_driver u_drv (
            .ref_clk(ref_clk),
            .rst(rst),
            .req(req[g]),
            .drv(drv[g])
        );
        assign pin_out[g] = drv[g].o;
        assign pin_oe[g] = drv[g].oe;
    end

    // Pins routed to the logic array as address inputs.
    assign addr_in_live = pin_sync & ADDR_IN_MASK;
    assign input_latch_cell = latch_reg;
    // Pins used by the select decode are address inputs.
    assign decode_addr_in = pin_sync & ADDR_IN_MASK & decode_use;

    // Host data from the data port pins, low byte on port F.
    assign data_port_wdata = {pin_sync[PORT_G], pin_sync[PORT_F]};
    // Peripheral read data from port F.
    assign periph_rdata = pin_sync[PORT_F];
    assign periph_mode = buffer_on;

    // Test inputs taken from the synchronised port E pins.
    assign jtag_tms = pin_sync[PORT_E][JT_TMS];
    assign jtag_tck = pin_sync[PORT_E][JT_TCK];
    assign jtag_tdi = pin_sync[PORT_E][JT_TDI];

endmodule : port_config_top
`default_nettype wire

// ---- tb/host_bus_model.sv ----
// Host model: register cycles and strap sampling at reset release.
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
    // Clock.
    input wire logic ref_clk,
    // Register cycles out, answers in.
    output var ioport_pkg::host_req_t host_req,
    input wire ioport_pkg::host_rsp_t host_rsp,
    // Host reset and its view of the data lines.
    input wire logic host_reset,
    input wire logic [15:0] data_lines,
    output var logic [15:0] boot_cfg
);
    import ioport_pkg::*;
    // The bus is idle until a task starts a cycle.
    initial host_req = '0;
    // The host takes its strap levels as its reset is released.
    always @(negedge host_reset) boot_cfg = data_lines;
    // One write, taken at the edge after the strobe is raised.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #1;
        host_req = '{1'b1, 1'b1, 1'b0, a, d};
        @(posedge ref_clk);
        #1;
        host_req = '0;
    endtask : wr
    // One read; a missing answer reads as unknown.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        #1;
        host_req = '{1'b1, 1'b0, 1'b1, a, 8'h00};
        @(posedge ref_clk);
        #1;
        d = (host_rsp.valid === 1'b1) ? host_rsp.data : 8'hXX;
        host_req = '0;
    endtask : rd
endmodule : host_bus_model
`default_nettype wire

// ---- tb/port_config_chk_asserts.sv ----
// Checker for the port configuration block.
`timescale 1ns/1ps
`default_nettype none
module port_config_chk (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst,
    // Host cycles.
    input wire ioport_pkg::host_req_t host_req,
    input wire ioport_pkg::host_rsp_t host_rsp,
    // Pins and logic terms.
    input wire ioport_pkg::port_vec_t pin_out,
    input wire ioport_pkg::port_vec_t pin_oe,
    input wire ioport_pkg::port_vec_t logic_oe_term,
    // Mode controls.
    input wire logic data_port_mode,
    input wire logic data_port_drive,
    input wire logic [15:0] data_port_rdata,
    input wire logic peripheral_select_zero,
    input wire logic peripheral_select_one,
    input wire logic periph_host_write,
    input wire logic [7:0] periph_wdata,
    input wire logic periph_mode,
    input wire logic reset_pattern_mode,
    input wire logic [15:0] reset_pattern,
    input wire logic host_reset,
    input wire logic bus_cycle_active,
    input wire logic jtag_enable,
    input wire logic jtag_tdo
);
    import ioport_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Port F belongs to the buffer only when no higher mode claims it.
    wire logic f_own = periph_mode && !data_port_mode && !reset_pattern_mode;
    chk_read_answer: assert property (host_req.sel && host_req.rd
        |=> host_rsp.valid) else $error("read got no answer");
    chk_valid_cause: assert property (host_rsp.valid
        |-> $past(host_req.sel) && $past(host_req.rd))
        else $error("answer without a read");
    chk_unmapped_zero: assert property (host_req.sel && host_req.rd
        && host_req.addr > 8'h28 |=> host_rsp.data == 8'h00)
        else $error("unmapped read not zero");
    chk_reset_quiet: assert property ($fell(rst)
        |-> pin_oe == '0 && !periph_mode) else $error("not quiet at reset");
    chk_oe_term_or: assert property ((pin_oe[2]
        & $past(logic_oe_term[2])) == $past(logic_oe_term[2]))
        else $error("logic enable term ignored");
    chk_buffer_drive: assert property (f_own && periph_host_write
        && (peripheral_select_zero || peripheral_select_one)
        |=> pin_oe[PORT_F] == 8'hFF && pin_out[PORT_F] == $past(periph_wdata))
        else $error("buffer not driving");
    chk_buffer_float: assert property (f_own && !peripheral_select_zero
        && !peripheral_select_one |=> pin_oe[PORT_F] == 8'h00)
        else $error("buffer drives while unselected");
    chk_data_port: assert property ((data_port_mode && data_port_drive
        && !host_reset)[*4] |=> {pin_oe[PORT_G], pin_oe[PORT_F]} == 16'hFFFF
        && {pin_out[PORT_G], pin_out[PORT_F]} == $past(data_port_rdata))
        else $error("data port not driving");
    chk_pattern_drive: assert property ((reset_pattern_mode
        && host_reset && !bus_cycle_active)[*4]
        |=> {pin_out[PORT_G], pin_out[PORT_F]} == $past(reset_pattern)
        && {pin_oe[PORT_G], pin_oe[PORT_F]} == 16'hFFFF)
        else $error("reset pattern not driven");
    chk_jtag_share: assert property (jtag_enable |=> pin_oe[PORT_E][3:0]
        == 4'h8 && pin_out[PORT_E][3] == $past(jtag_tdo))
        else $error("test access pins wrong");
endmodule : port_config_chk
bind port_config_top port_config_chk u_chk (.*);
`default_nettype wire

// ---- tb/test_multi_mode_io_port_config.sv ----
// Testbench for the port configuration block.
`timescale 1ns/1ps
`default_nettype none
module test_multi_mode_io_port_config;
    import ioport_pkg::*;
    logic ref_clk, rst, address_latch_strobe, data_port_mode;
    logic data_port_drive, peripheral_select_zero, peripheral_select_one;
    logic periph_host_write, periph_mode, reset_pattern_mode, host_reset;
    logic bus_cycle_active, jtag_enable, jtag_tdo, jtag_tms, jtag_tck, jtag_tdi;
    logic [15:0] data_port_rdata, data_port_wdata, reset_pattern, boot_cfg;
    logic [7:0] periph_wdata, periph_rdata, rv, p;
    host_req_t host_req;
    host_rsp_t host_rsp;
    port_vec_t pin_in, pin_out, pin_oe, logic_out_val, logic_oe_term;
    port_vec_t addr_out_val, decode_use, addr_in_live, input_latch_cell;
    port_vec_t decode_addr_in;
    int fails = 0, comparisons = 0;
    // Host data lines, pulled up where the pins are released.
    wire logic [15:0] data_lines = {pin_out[6] | ~pin_oe[6],
        pin_out[5] | ~pin_oe[5]};
    port_config_top dut (.ref_clk, .rst, .host_req, .host_rsp, .pin_in,
        .pin_out, .pin_oe, .logic_out_val, .logic_oe_term, .addr_out_val,
        .decode_use, .address_latch_strobe, .addr_in_live, .input_latch_cell,
        .decode_addr_in, .data_port_mode, .data_port_drive, .data_port_rdata,
        .data_port_wdata, .peripheral_select_zero, .peripheral_select_one,
        .periph_host_write, .periph_wdata, .periph_rdata, .periph_mode,
        .reset_pattern_mode, .reset_pattern, .host_reset, .bus_cycle_active,
        .jtag_enable, .jtag_tdo, .jtag_tms, .jtag_tck, .jtag_tdi);
    host_bus_model u_host (.ref_clk, .host_req, .host_rsp, .host_reset,
        .data_lines, .boot_cfg);
    // Free-running 125 MHz clock.
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // Compares one byte and counts it.
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // Waits n edges, then steps off the edge.
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick
    // Prints the counts and the verdict.
    task automatic conclude();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude
    // Reads a register and compares it.
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        u_host.rd(a, rv);
        chk(rv, e);
    endtask : rchk
    // Cuts a hang short.
    initial begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        conclude();
    end
    // Main sequence.
    initial begin
        {address_latch_strobe, data_port_mode, data_port_drive} = '0;
        {peripheral_select_zero, peripheral_select_one, periph_host_write} = '0;
        {reset_pattern_mode, host_reset, bus_cycle_active, jtag_enable} = '0;
        {jtag_tdo, data_port_rdata, reset_pattern, periph_wdata} = '0;
        {pin_in, logic_out_val, logic_oe_term, addr_out_val, decode_use} = '0;
        rst = 1'b1;
        tick(3);
        rst = 1'b0;
        // Defaults, then implemented bits of the direction, drive and mode registers.
        for (p = 8'h00; p < NPORT; p++) begin
            rchk(OFS_DIR + p, CFG_RST);
            rchk(OFS_DRV + p, CFG_RST);
            rchk(OFS_MODE + p, CFG_RST);
            u_host.wr(OFS_DIR + p, 8'hFF);
            u_host.wr(OFS_DRV + p, 8'hFF);
            u_host.wr(OFS_MODE + p, 8'hFF);
            rchk(OFS_DIR + p, DIR_MASK[p]);
            rchk(OFS_DRV + p, DRV_MASK[p]);
            rchk(OFS_MODE + p, MODE_MASK[p]);
            u_host.wr(OFS_DIR + p, 8'h00);
            u_host.wr(OFS_DRV + p, 8'h00);
            u_host.wr(OFS_MODE + p, 8'h00);
        end
        // Port A: one output pin, then open drain.
        u_host.wr(OFS_DOUT, 8'h0F);
        u_host.wr(OFS_DIR, 8'h01);
        tick(2);
        chk(pin_oe[0], 8'h01);
        chk(pin_out[0] & 8'h01, 8'h01);
        rchk(OFS_DOUT, 8'h0F);
        u_host.wr(OFS_DIR, 8'hFF);
        u_host.wr(OFS_DRV, 8'hFF);
        tick(2);
        chk(pin_oe[0], 8'hF0);
        chk(pin_out[0] & 8'hF0, 8'h00);
        u_host.wr(OFS_DRV, 8'h00);
        tick(2);
        chk(pin_oe[0], 8'hFF);
        chk(pin_out[0], 8'h0F);
        u_host.wr(OFS_DIR, 8'h00);
        // Logic enable term ORed with direction on port C.
        logic_oe_term[2] = 8'h0F;
        logic_out_val[2] = 8'hA5;
        u_host.wr(OFS_DIR + 8'h02, 8'h30);
        tick(2);
        chk(pin_oe[2], 8'h3F);
        chk(pin_out[2], 8'h05);
        logic_oe_term[2] = 8'h00;
        // Address out on pin E0 only, host output on E1.
        addr_out_val[4] = 8'h81;
        u_host.wr(OFS_MODE + 8'h04, 8'h01);
        u_host.wr(OFS_DIR + 8'h04, 8'h03);
        tick(2);
        chk(pin_out[4] & 8'h03, 8'h01);
        chk(pin_oe[4] & 8'h03, 8'h03);
        u_host.wr(OFS_MODE + 8'h04, 8'h00);
        u_host.wr(OFS_DIR + 8'h04, 8'h00);
        // Live inputs, address inputs and the latch cell.
        {pin_in[0], pin_in[1], pin_in[4]} = {8'hA6, 8'h3C, 8'h05};
        {decode_use[0], address_latch_strobe} = {8'h0F, 1'b1};
        u_host.wr(OFS_DIN + 8'h01, 8'h00);
        u_host.wr(8'h30, 8'h55);
        rchk(OFS_DIN + 8'h01, 8'h3C);
        rchk(8'h30, 8'h00);
        chk(addr_in_live[0], 8'hA6);
        chk(addr_in_live[4], 8'h00);
        chk(decode_addr_in[0], 8'h06);
        chk(input_latch_cell[0], 8'hA6);
        address_latch_strobe = 1'b0;
        tick(2);
        pin_in[0] = 8'h11;
        tick(4);
        chk(input_latch_cell[0], 8'hA6);
        // Test access pins shared on port E.
        {jtag_enable, jtag_tdo} = 2'b11;
        tick(4);
        chk({5'h00, jtag_tdi, jtag_tck, jtag_tms}, 8'h05);
        chk(pin_out[4] & 8'h08, 8'h08);
        jtag_enable = 1'b0;
        // Peripheral buffer on port F, direction bits set meanwhile.
        u_host.wr(OFS_MAP, 8'h80);
        u_host.wr(OFS_DIR + 8'h05, 8'hFF);
        rchk(OFS_MAP, 8'h80);
        {peripheral_select_zero, periph_host_write} = 2'b11;
        periph_wdata = 8'h5A;
        tick(2);
        chk(pin_oe[5], 8'hFF);
        chk(pin_out[5], 8'h5A);
        {peripheral_select_zero, peripheral_select_one} = 2'b01;
        {periph_host_write, pin_in[5]} = {1'b0, 8'hC3};
        tick(4);
        chk(periph_rdata, 8'hC3);
        peripheral_select_one = 1'b0;
        tick(2);
        chk(pin_oe[5], 8'h00);
        u_host.wr(OFS_MAP, 8'h00);
        // Data port on F and G in both directions.
        {data_port_mode, data_port_drive, data_port_rdata} = {2'b11, 16'h1234};
        tick(2);
        chk(pin_out[5], 8'h34);
        chk(pin_out[6], 8'h12);
        {data_port_drive, pin_in[6], pin_in[5]} = {1'b0, 16'h5678};
        tick(4);
        chk(pin_oe[5], 8'h00);
        chk(data_port_wdata[15:8], 8'h56);
        // Reset pattern: held off by a bus cycle, then driven.
        {reset_pattern_mode, host_reset, bus_cycle_active} = 3'b111;
        reset_pattern = 16'hC35A;
        tick(6);
        chk(pin_oe[5], 8'h00);
        bus_cycle_active = 1'b0;
        tick(6);
        chk(pin_out[5], 8'h5A);
        chk(pin_out[6], 8'hC3);
        data_port_drive = 1'b1;
        host_reset = 1'b0;
        tick(6);
        chk(boot_cfg[15:8], 8'hC3);
        chk(boot_cfg[7:0], 8'h5A);
        chk(pin_out[5], 8'h34);
        chk(pin_out[6], 8'h12);
        conclude();
    end
endmodule : test_multi_mode_io_port_config
`default_nettype wire
